// *** logic/pmrc_pkg.sv ***
// Constants for the power management and reset controller
package pmrc_pkg;

    // Clock
    localparam int unsigned MCLK_HZ          = 40_000_000;
    localparam int unsigned MCLK_PERIOD_NS   = 25;

    // Reset pulse: typical 0.7 ms, longest 2 ms
    localparam int unsigned RESET_TYP_US     = 700;
    localparam int unsigned RESET_MAX_US     = 2000;
    localparam int unsigned RESET_TYP_CYC    = (RESET_TYP_US * (MCLK_HZ / 1_000_000));
    localparam int unsigned RESET_MAX_CYC    = (RESET_MAX_US * (MCLK_HZ / 1_000_000));
    localparam int unsigned RESET_CNT_W      = 17;

    // Shutdown hold width: 1 unit, taken as 1 us
    localparam int unsigned SDN_HOLD_NS      = 1000;
    localparam int unsigned SDN_HOLD_CYC     = (SDN_HOLD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int unsigned HOLD_CNT_W       = 6;

    // Chip select wake figures, obligations of the host
    localparam int unsigned CS_WAKE_LP_US    = 40;
    localparam int unsigned CS_WAKE_RDY_NS   = 30;

    // Regulator level code
    localparam int unsigned LVL_W            = 3;
    localparam logic [2:0]  LVL_1V2          = 3'h1;
    localparam logic [2:0]  LVL_1V4          = 3'h3;
    localparam logic [2:0]  LVL_1V8          = 3'h7;
    localparam logic [2:0]  LVL_RESET        = 3'h3;
    localparam int unsigned MV_BASE          = 1100;
    localparam int unsigned MV_STEP          = 100;
    localparam int unsigned MV_W             = 11;

    // Switching clock
    localparam int unsigned RATE_W           = 15;
    localparam int unsigned ACC_W            = 16;
    localparam logic [14:0] RATE_RESET       = 15'h0000;
    localparam int unsigned DIV_FIXED        = 4;

    // Digital clock derived from crystal
    localparam int unsigned XO_HIGH_MIN_MHZ  = 48;

    // Radio states as seen by the regulator
    typedef enum logic [1:0] {
        PMRC_IDLE = 2'b00,
        PMRC_RX   = 2'b01,
        PMRC_TX   = 2'b10
    } pmrc_radio_e;

    // Reset sequencer states
    typedef enum logic [1:0] {
        PMRC_RST_PULSE = 2'b00,
        PMRC_RST_RUN   = 2'b01,
        PMRC_RST_SHUT  = 2'b10
    } pmrc_rst_e;

endpackage

// *** logic/pmrc_sw_clk.sv ***
// Regulator switching clock generator: fixed divide or fractional rate
`timescale 1ns/1ps
module pmrc_sw_clk
    import pmrc_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              dig_en,
    input  wire logic              fractional_switch_enable,
    input  wire logic [RATE_W-1:0] switch_rate_word,
    output logic                   sw_clk
);

    logic [ACC_W-1:0] acc;
    logic [1:0]       div;
    wire  [ACC_W-1:0] next_acc  = acc + {1'b0, switch_rate_word};
    wire  [1:0]       next_div  = div + 2'h1;
    wire              frac_clk  = acc[RATE_W-1];
    wire              fixed_clk = div[1];

    // Bit 14 wraps every 2^15/rate steps: rate*fdig/2^15; bit 15 is spare
    always_ff @(posedge mclk) begin
        if (rst) begin
            acc <= '0;
            div <= '0;
        end else if (dig_en) begin
            acc <= fractional_switch_enable ? next_acc : '0;
            div <= next_div;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sw_clk <= 1'b0;
        end else begin
            sw_clk <= fractional_switch_enable ? frac_clk : fixed_clk;
        end
    end

    fixed_div_a: assert property (@(posedge mclk) disable iff (rst)
        (!$past(rst) && $past(dig_en))
        |-> (div == $past(div) + 2'h1))
        else $error("fixed divider did not advance");

    frac_acc_a: assert property (@(posedge mclk) disable iff (rst)
        (!$past(rst) && $past(dig_en) && $past(fractional_switch_enable) && fractional_switch_enable)
        |-> (acc == ACC_W'($past(acc) + {1'b0, $past(switch_rate_word)})))
        else $error("fractional accumulator wrong step");

endmodule

// *** logic/pmrc_top.sv ***
// Power management and reset controller of the transceiver digital side
`timescale 1ns/1ps
module pmrc_top
    import pmrc_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    // Pins from outside the clock domain
    input  wire logic              shutdown_input,
    input  wire logic              supply_good,
    input  wire logic              chip_select_n,
    input  wire logic              low_battery,
    input  wire logic              lock_detect,
    // Configuration from the serial port (same clock)
    input  wire logic              cfg_we,
    input  wire logic [LVL_W-1:0]  cfg_level_code,
    input  wire logic              cfg_level_scope,
    input  wire logic              cfg_frac_enable,
    input  wire logic [RATE_W-1:0] cfg_rate_word,
    input  wire logic              cfg_bypass_select,
    input  wire logic              cfg_batt_protect,
    input  wire logic              cfg_xo_double,
    input  wire logic              soft_reset_command,
    input  wire pmrc_radio_e       radio_state,
    // Outputs
    output logic                   internal_reset_n,
    output logic                   partial_reset,
    output logic                   general_pin_zero,
    output logic                   io_disable_control,
    output logic [MV_W-1:0]        regulator_target_mv,
    output logic                   regulator_bypass_select,
    output logic                   sw_clk,
    output logic                   dig_clk_en,
    output logic                   pa_enable,
    output logic                   cs_wake_pending,
    output logic [LVL_W-1:0]       regulator_level_code,
    output logic                   regulator_level_scope,
    output logic                   fractional_switch_enable,
    output logic [RATE_W-1:0]      switch_rate_word
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] sdn_sync;
    logic [1:0] sup_sync;
    logic [1:0] cs_sync;
    logic [1:0] bat_sync;
    logic [1:0] lock_sync;
    logic       sdn_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            sdn_sync  <= 2'h0;
            sup_sync  <= 2'h0;
            cs_sync   <= 2'h3;
            bat_sync  <= 2'h0;
            lock_sync <= 2'h0;
            sdn_q     <= 1'b0;
        end else begin
            sdn_sync  <= {sdn_sync[0], shutdown_input};
            sup_sync  <= {sup_sync[0], supply_good};
            cs_sync   <= {cs_sync[0], chip_select_n};
            bat_sync  <= {bat_sync[0], low_battery};
            lock_sync <= {lock_sync[0], lock_detect};
            sdn_q     <= sdn_sync[1];
        end
    end

    wire sdn_s    = sdn_sync[1];
    wire sup_s    = sup_sync[1];
    wire cs_n_s   = cs_sync[1];
    wire sdn_fall = sdn_q && !sdn_s;

    // ----------------------------------------------------------------
    // Shutdown hold filter
    // ----------------------------------------------------------------
    // A shutdown shorter than the hold width leaves the reset sequencer running; only io disable follows it
    logic [HOLD_CNT_W-1:0] hold_cnt;
    wire  hold_met  = (hold_cnt >= HOLD_CNT_W'(SDN_HOLD_CYC));
    wire  [HOLD_CNT_W-1:0] next_hold = hold_met ? hold_cnt : hold_cnt + HOLD_CNT_W'(1);
    logic shut_seen;

    always_ff @(posedge mclk) begin
        if (rst) begin
            hold_cnt  <= '0;
            shut_seen <= 1'b0;
        end else begin
            hold_cnt  <= sdn_s ? next_hold : '0;
            shut_seen <= sdn_s ? (shut_seen || hold_met) : (shut_seen && !sdn_fall);
        end
    end

    // ----------------------------------------------------------------
    // Reset sequencer
    // ----------------------------------------------------------------
    pmrc_rst_e               rst_state;
    pmrc_rst_e               next_rst_state;
    logic [RESET_CNT_W-1:0]  rst_cnt;
    wire  pulse_done  = (rst_cnt == RESET_CNT_W'(RESET_TYP_CYC - 1));
    wire  sdn_restart = sdn_fall && shut_seen && sup_s;
    wire  [RESET_CNT_W-1:0] next_rst_cnt = (rst_state == PMRC_RST_PULSE && sup_s && !pulse_done)
                                           ? rst_cnt + RESET_CNT_W'(1) : '0;

    always_comb begin
        next_rst_state = rst_state;
        case (rst_state)
            PMRC_RST_PULSE: if (pulse_done) next_rst_state = PMRC_RST_RUN;
            PMRC_RST_RUN:   if (sdn_s && hold_met) next_rst_state = PMRC_RST_SHUT;
            PMRC_RST_SHUT:  if (sdn_restart) next_rst_state = PMRC_RST_PULSE;
            default:        next_rst_state = PMRC_RST_PULSE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rst_state <= PMRC_RST_PULSE;
            rst_cnt   <= '0;
        end else begin
            rst_state <= next_rst_state;
            rst_cnt   <= next_rst_cnt;
        end
    end

    // Registered release keeps every consumer on one edge
    wire next_reset_n = (next_rst_state != PMRC_RST_PULSE);

    always_ff @(posedge mclk) begin
        if (rst) begin
            internal_reset_n <= 1'b0;
            general_pin_zero <= 1'b0;
        end else begin
            internal_reset_n <= next_reset_n;
            general_pin_zero <= next_reset_n;
        end
    end

    // Shutdown drives io disable directly from the synchronised pin
    always_ff @(posedge mclk) begin
        if (rst) begin
            io_disable_control <= 1'b1;
        end else begin
            io_disable_control <= sdn_s;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    wire full_rst = rst || !internal_reset_n;

    always_ff @(posedge mclk) begin
        if (full_rst) begin
            regulator_level_code     <= LVL_RESET;
            regulator_level_scope    <= 1'b0;
            fractional_switch_enable <= 1'b0;
            switch_rate_word         <= RATE_RESET;
            regulator_bypass_select  <= 1'b0;
        end else if (cfg_we) begin
            regulator_level_code     <= cfg_level_code;
            regulator_level_scope    <= cfg_level_scope;
            fractional_switch_enable <= cfg_frac_enable;
            switch_rate_word         <= cfg_rate_word;
            regulator_bypass_select  <= cfg_bypass_select;
        end
    end

    // Soft reset spares configuration; only the run logic is cleared
    logic batt_protect;
    logic xo_double;
    logic dig_div;

    always_ff @(posedge mclk) begin
        if (full_rst) begin
            partial_reset <= 1'b0;
            batt_protect  <= 1'b1;
            xo_double     <= 1'b0;
        end else begin
            partial_reset <= soft_reset_command;
            if (cfg_we) begin
                batt_protect <= cfg_batt_protect;
                xo_double    <= cfg_xo_double;
            end
        end
    end

    // ----------------------------------------------------------------
    // Digital clock enable and switching clock
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (full_rst || partial_reset) begin
            dig_div <= 1'b0;
        end else begin
            dig_div <= !dig_div;
        end
    end

    assign dig_clk_en = xo_double ? dig_div : 1'b1;

    pmrc_sw_clk u_sw_clk (
        .mclk                     (mclk),
        .rst                      (full_rst || partial_reset),
        .dig_en                   (dig_clk_en),
        .fractional_switch_enable (fractional_switch_enable),
        .switch_rate_word         (switch_rate_word),
        .sw_clk                   (sw_clk)
    );

    // ----------------------------------------------------------------
    // Regulator level
    // ----------------------------------------------------------------
    wire              fix_rx    = regulator_level_scope && (radio_state == PMRC_RX);
    wire [LVL_W-1:0]  eff_level = fix_rx ? LVL_1V4 : regulator_level_code;
    wire [LVL_W-1:0]  min_level = (eff_level == 3'h0) ? LVL_1V2 : eff_level;
    wire [MV_W-1:0]   next_mv   = MV_W'(MV_BASE + MV_STEP * min_level);

    always_ff @(posedge mclk) begin
        if (full_rst) begin
            regulator_target_mv <= MV_W'(MV_BASE + MV_STEP * LVL_RESET);
        end else begin
            regulator_target_mv <= next_mv;
        end
    end

    // ----------------------------------------------------------------
    // Low battery transmit protection and chip select wake
    // ----------------------------------------------------------------
    wire tx_safe = !batt_protect || (!bat_sync[1] && lock_sync[1]);

    always_ff @(posedge mclk) begin
        if (full_rst || partial_reset) begin
            pa_enable       <= 1'b0;
            cs_wake_pending <= 1'b0;
        end else begin
            pa_enable       <= (radio_state == PMRC_TX) && tx_safe;
            cs_wake_pending <= !cs_n_s && (radio_state == PMRC_IDLE);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    rst_release_a: assert property (@(posedge mclk) disable iff (rst)
        ($rose(internal_reset_n)) |-> $past(rst_cnt) == RESET_CNT_W'(RESET_TYP_CYC - 1))
        else $error("reset released before pulse length");

    pin_zero_a: assert property (@(posedge mclk) disable iff (rst)
        general_pin_zero == internal_reset_n)
        else $error("pin zero differs from internal reset");

    rx_level_a: assert property (@(posedge mclk) disable iff (full_rst)
        ($past(regulator_level_scope) && $past(radio_state) == PMRC_RX && !$past(full_rst))
        |-> regulator_target_mv == MV_W'(1400))
        else $error("receive level not fixed at 1.4 V");

    tx_level_a: assert property (@(posedge mclk) disable iff (full_rst)
        (!$past(regulator_level_scope) && $past(regulator_level_code) == LVL_1V8 && !$past(full_rst))
        |-> regulator_target_mv == MV_W'(1800))
        else $error("programmed level not applied");

    io_disable_a: assert property (@(posedge mclk) disable iff (rst)
        sdn_s |=> io_disable_control)
        else $error("io not disabled in shutdown");

    sdn_pulse_a: assert property (@(posedge mclk) disable iff (rst)
        (rst_state == PMRC_RST_SHUT && sdn_restart) |=> !internal_reset_n [*8])
        else $error("shutdown release without reset pulse");

    cfg_default_a: assert property (@(posedge mclk) disable iff (rst)
        !$past(internal_reset_n) |-> (regulator_level_code == LVL_RESET && !fractional_switch_enable))
        else $error("settings not at defaults after reset");

    soft_keep_a: assert property (@(posedge mclk) disable iff (full_rst)
        (partial_reset && !cfg_we) |=> $stable(regulator_level_code))
        else $error("soft reset changed configuration");

    batt_stop_a: assert property (@(posedge mclk) disable iff (full_rst || partial_reset)
        (batt_protect && bat_sync[1]) |=> !pa_enable)
        else $error("transmit kept on low battery");

    div_en_a: assert property (@(posedge mclk) disable iff (full_rst || partial_reset)
        (xo_double && dig_clk_en && !cfg_we) |=> !dig_clk_en)
        else $error("digital clock not halved");

    pulse_c:   cover property (@(posedge mclk) $rose(internal_reset_n));
    shut_c:    cover property (@(posedge mclk) rst_state == PMRC_RST_SHUT ##1 rst_state == PMRC_RST_PULSE);
    rxfix_c:   cover property (@(posedge mclk) fix_rx && regulator_level_code == LVL_1V8);
    battoff_c: cover property (@(posedge mclk) radio_state == PMRC_TX && batt_protect && !tx_safe);

endmodule

// *** tb/pmrc_host_model.sv ***
// Host side model: shutdown pin and chip select timing
`timescale 1ns/1ps
module pmrc_host_model
    import pmrc_pkg::*;
(
    input  wire logic mclk,
    output logic      shutdown_input,
    output logic      chip_select_n
);
    initial begin
        shutdown_input = 1'b0;
        chip_select_n  = 1'b1;
    end

    // ------------------------------------------------------------
    // Host requests
    // ------------------------------------------------------------
    task automatic hold_shutdown(input int cycles);
        @(posedge mclk);
        #2;
        shutdown_input = 1'b1;
        repeat (cycles) @(posedge mclk);
        #2;
        shutdown_input = 1'b0;
    endtask

    // Waits before the first serial edge would be allowed
    task automatic select(input logic low_power);
        @(posedge mclk);
        #2;
        chip_select_n = 1'b0;
        if (low_power) begin
            repeat (CS_WAKE_LP_US * 1000 / MCLK_PERIOD_NS) @(posedge mclk);
        end else begin
            repeat (2) @(posedge mclk);
        end
        #2;
        chip_select_n = 1'b1;
    endtask
endmodule

// *** tb/power_mgmt_and_reset_ctrl_tb.sv ***
// Self-checking testbench for the power management and reset controller
`timescale 1ns/1ps
module power_mgmt_and_reset_ctrl_tb
    import pmrc_pkg::*;
    ;
    logic              mclk, rst, shutdown_input, supply_good, chip_select_n, low_battery, lock_detect;
    logic              cfg_we, cfg_level_scope, cfg_frac_enable, cfg_bypass_select, cfg_batt_protect;
    logic              cfg_xo_double, soft_reset_command;
    logic [LVL_W-1:0]  cfg_level_code;
    logic [RATE_W-1:0] cfg_rate_word;
    pmrc_radio_e       radio_state;
    logic              internal_reset_n, partial_reset, general_pin_zero, io_disable_control;
    logic [MV_W-1:0]   regulator_target_mv;
    logic              regulator_bypass_select, sw_clk, dig_clk_en, pa_enable, cs_wake_pending;
    logic [LVL_W-1:0]  regulator_level_code;
    logic              regulator_level_scope, fractional_switch_enable;
    logic [RATE_W-1:0] switch_rate_word;
    int                miscompares = 0;
    int                checks_done = 0;
    int                cycles      = 0;
    int                n;

    pmrc_top dut_u (.mclk(mclk), .rst(rst), .shutdown_input(shutdown_input), .supply_good(supply_good),
        .chip_select_n(chip_select_n), .low_battery(low_battery), .lock_detect(lock_detect), .cfg_we(cfg_we),
        .cfg_level_code(cfg_level_code), .cfg_level_scope(cfg_level_scope), .cfg_frac_enable(cfg_frac_enable),
        .cfg_rate_word(cfg_rate_word), .cfg_bypass_select(cfg_bypass_select),
        .cfg_batt_protect(cfg_batt_protect), .cfg_xo_double(cfg_xo_double),
        .soft_reset_command(soft_reset_command), .radio_state(radio_state),
        .internal_reset_n(internal_reset_n), .partial_reset(partial_reset),
        .general_pin_zero(general_pin_zero), .io_disable_control(io_disable_control),
        .regulator_target_mv(regulator_target_mv), .regulator_bypass_select(regulator_bypass_select),
        .sw_clk(sw_clk), .dig_clk_en(dig_clk_en), .pa_enable(pa_enable), .cs_wake_pending(cs_wake_pending),
        .regulator_level_code(regulator_level_code), .regulator_level_scope(regulator_level_scope),
        .fractional_switch_enable(fractional_switch_enable), .switch_rate_word(switch_rate_word));

    pmrc_host_model host_u (.mclk(mclk), .shutdown_input(shutdown_input), .chip_select_n(chip_select_n));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #2;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] code, input logic scope, input logic frac, input logic [14:0] rate,
                      input logic byp, input logic prot, input logic xo);
        cfg_level_code    = code;
        cfg_level_scope   = scope;
        cfg_frac_enable   = frac;
        cfg_rate_word     = rate;
        cfg_bypass_select = byp;
        cfg_batt_protect  = prot;
        cfg_xo_double     = xo;
        cfg_we            = 1'b1;
        cyc(1);
        cfg_we = 1'b0;
        cyc(2);
    endtask

    // Cycles until the internal reset lets go, bounded by the longest pulse
    task automatic wait_release(output int k);
        k = 0;
        while (internal_reset_n !== 1'b1 && k < RESET_MAX_CYC) begin
            cyc(1);
            k++;
        end
    endtask

    // Counts high samples of a signal or rising edges of the switching clock
    task automatic count_sw(input int span, input logic edges, output int e);
        logic prev;
        e    = 0;
        prev = edges ? sw_clk : 1'b0;
        repeat (span) begin
            cyc(1);
            if (edges ? (sw_clk === 1'b1 && prev === 1'b0) : (dig_clk_en === 1'b1)) e++;
            prev = sw_clk;
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Ceiling: two reset pulses, one slow wake and the short tests
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            miscompares++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1; supply_good = 1'b1; low_battery = 1'b0; lock_detect = 1'b1; cfg_we = 1'b0;
        cfg_level_code = 3'h0; cfg_level_scope = 1'b0; cfg_frac_enable = 1'b0; cfg_rate_word = 15'h0000;
        cfg_bypass_select = 1'b0; cfg_batt_protect = 1'b1; cfg_xo_double = 1'b0;
        soft_reset_command = 1'b0; radio_state = PMRC_IDLE;
        cyc(2);
        chk(internal_reset_n, 1'b0);
        chk(io_disable_control, 1'b1);
        chk(regulator_target_mv, 11'h578);
        rst = 1'b0;
        wait_release(n);
        chk(n >= RESET_TYP_CYC - 10 && n < RESET_MAX_CYC, 1'b1);
        chk(general_pin_zero, internal_reset_n);
        $display("test power-up reset done");

        // Code 010 lies between both bypass limits; it is driven for the mapping only
        for (int c = 1; c < 8; c++) begin
            wr(c[2:0], 1'b0, 1'b0, 15'h0000, c == 1, 1'b1, 1'b0);
            chk(regulator_bypass_select, c == 1);
            radio_state = PMRC_RX;
            cyc(3);
            chk(regulator_target_mv, MV_BASE + MV_STEP * c);
            radio_state = PMRC_TX;
            cyc(3);
            chk(regulator_target_mv, MV_BASE + MV_STEP * c);
            wr(c[2:0], 1'b1, 1'b0, 15'h0000, c == 1, 1'b1, 1'b0);
            cyc(3);
            chk(regulator_target_mv, MV_BASE + MV_STEP * c);
            radio_state = PMRC_RX;
            cyc(3);
            chk(regulator_target_mv, 11'h578);
        end
        $display("test regulator levels done");

        wr(3'h3, 1'b0, 1'b0, 15'h0000, 1'b0, 1'b1, 1'b0);
        count_sw(400, 1'b1, n);
        chk(n >= 99 && n <= 101, 1'b1);
        wr(3'h3, 1'b0, 1'b1, 15'h1000, 1'b0, 1'b1, 1'b0);
        count_sw(400, 1'b1, n);
        chk(n >= 49 && n <= 51, 1'b1);
        chk(fractional_switch_enable, 1'b1);
        wr(3'h3, 1'b0, 1'b0, 15'h0000, 1'b0, 1'b1, 1'b1);
        count_sw(100, 1'b0, n);
        chk(n >= 49 && n <= 51, 1'b1);
        count_sw(400, 1'b1, n);
        chk(n >= 49 && n <= 51, 1'b1);
        $display("test switching clock done");

        radio_state = PMRC_TX;
        wr(3'h4, 1'b0, 1'b0, 15'h0000, 1'b0, 1'b1, 1'b0);
        cyc(8);
        chk(pa_enable, 1'b1);
        low_battery = 1'b1;
        cyc(8);
        chk(pa_enable, 1'b0);
        wr(3'h4, 1'b0, 1'b0, 15'h0000, 1'b0, 1'b0, 1'b0);
        cyc(8);
        chk(pa_enable, 1'b1);
        low_battery = 1'b0;
        lock_detect = 1'b0;
        wr(3'h4, 1'b0, 1'b0, 15'h0000, 1'b0, 1'b1, 1'b0);
        cyc(8);
        chk(pa_enable, 1'b0);
        lock_detect = 1'b1;
        radio_state = PMRC_IDLE;
        $display("test battery protection done");

        wr(3'h5, 1'b0, 1'b0, 15'h0000, 1'b0, 1'b1, 1'b0);
        soft_reset_command = 1'b1;
        cyc(1);
        soft_reset_command = 1'b0;
        chk(partial_reset, 1'b1);
        cyc(2);
        chk(internal_reset_n, 1'b1);
        chk(regulator_level_code, 3'h5);
        $display("test soft reset done");

        fork
            host_u.select(1'b1);
            begin
                cyc(10);
                chk(cs_wake_pending, 1'b1);
            end
        join
        cyc(4);
        chk(cs_wake_pending, 1'b0);
        host_u.select(1'b0);
        wr(3'h7, 1'b1, 1'b1, 15'h1000, 1'b0, 1'b1, 1'b0);
        host_u.hold_shutdown(10);
        cyc(10);
        chk(internal_reset_n, 1'b1);
        fork
            host_u.hold_shutdown(60);
            begin
                cyc(55);
                chk(io_disable_control, 1'b1);
            end
        join
        cyc(10);
        chk(internal_reset_n, 1'b0);
        chk(general_pin_zero, 1'b0);
        chk(io_disable_control, 1'b0);
        chk(regulator_level_code, LVL_RESET);
        chk(switch_rate_word, RATE_RESET);
        chk(regulator_level_scope, 1'b0);
        wait_release(n);
        chk(n >= RESET_TYP_CYC - 20 && n < RESET_MAX_CYC, 1'b1);
        $display("test shutdown reset done");
        close_out();
    end
endmodule
